/* rtl/iapc_cfg_bank.v */
// Configuration bank: io_address_select, power_and_test, function_control and
// printer_port_control, reached via a shared index/data port.
// Assumes the host port strobes are synchronous one-cycle pulses on core_clk;
// external pins and peripheral status arrive asynchronously and are synchronised.
`timescale 1ns/1ps
`include "iapc_map.vh"
module iapc_cfg_bank (
   input wire core_clk,
   input wire rst_n,
   // Host index/data port
   input wire idxWrite,
   input wire dataWrite,
   input wire dataRead,
   input wire [7:0] hostWrData,
   output reg [7:0] hostRdData,
   // Registers owned elsewhere
   input wire [7:0] functionEnable,
   input wire [7:0] plugPlayCfg0,
   input wire [7:0] plugPlayCfg1,
   input wire enhancedTapeSelect,
   // Asynchronous peripheral status
   input wire portCtrlBit4,
   input wire [2:0] portCtrlLow,
   input wire modemCtrl1Bit3,
   input wire modemCtrl1Bit4,
   input wire modemCtrl2Bit3,
   input wire modemCtrl2Bit4,
   input wire lineCtrl1Bit7,
   input wire lineCtrl2Bit7,
   input wire baudClk1,
   input wire baudClk2,
   input wire uartOut1,
   input wire uartOut2,
   input wire fastCycleReady,
   input wire parIrqRaw,
   input wire uart1Irq,
   input wire uart2Irq,
   input wire [1:0] powerDownMode,
   // Decoded configuration
   output reg [9:0] parBase,
   output reg parDecodeEn,
   output reg [9:0] uart1Base,
   output reg [9:0] uart2Base,
   output reg [2:0] parMode,
   output reg parLevelIrq,
   output reg eppRegsEn,
   output reg ecpRegsEn,
   output reg ecpClkRun,
   output reg ctrlPushPull,
   output reg softPowerDown,
   output reg tapeCompat,
   output reg ideDmaEn,
   output reg rtcRamWriteEn,
   output reg serialOut1,
   output reg serialOut2,
   // Interrupt and zero-wait pins: output and enable
   output reg irq3Out,
   output reg irq3Oe,
   output reg irq4Out,
   output reg irq4Oe,
   output reg irq5Out,
   output reg irq5Oe,
   output reg irq7Out,
   output reg irq7Oe,
   output reg zeroWaitOut,
   output reg zeroWaitOe
);
   // ************************************************************
   // Registers
   // ************************************************************
   reg [7:0] index_q; // Shared index
   reg [7:0] ioAddr_q; // io_address_select
   reg [7:0] powerTest_q; // power_and_test
   reg [7:0] funcCtrl_q; // function_control
   reg [7:0] prnCtrl_q; // printer_port_control
   // Two-stage synchronisers; stage one read only by stage two
   localparam SW = 20;
   reg [SW-1:0] sync1_q;
   reg [SW-1:0] sync2_q;
   wire [SW-1:0] asyncIn;
   assign asyncIn = {portCtrlBit4, portCtrlLow, modemCtrl1Bit3, modemCtrl1Bit4,
      modemCtrl2Bit3, modemCtrl2Bit4, lineCtrl1Bit7, lineCtrl2Bit7, baudClk1,
      baudClk2, uartOut1, uartOut2, fastCycleReady, parIrqRaw, uart1Irq,
      uart2Irq, powerDownMode};
   wire sCtr4 = sync2_q[19];
   wire [2:0] sCtrLow = sync2_q[18:16];
   wire sMcr13 = sync2_q[15];
   wire sMcr14 = sync2_q[14];
   wire sMcr23 = sync2_q[13];
   wire sMcr24 = sync2_q[12];
   wire sLcr1 = sync2_q[11];
   wire sLcr2 = sync2_q[10];
   wire sBaud1 = sync2_q[9];
   wire sBaud2 = sync2_q[8];
   wire serial_out_1 = sync2_q[7];
   wire serial_out_2 = sync2_q[6];
   wire sFast = sync2_q[5];
   wire sParIrq = sync2_q[4];
   wire sU1Irq = sync2_q[3];
   wire sU2Irq = sync2_q[2];
   wire [1:0] sPdMode = sync2_q[1:0];

   // ************************************************************
   // Synchroniser
   // ************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= {SW{1'b0}};
         sync2_q <= {SW{1'b0}};
      end else begin
         sync1_q <= asyncIn;
         sync2_q <= sync1_q;
      end
   end

   // ************************************************************
   // Host port and register writes
   // ************************************************************
   // Lock sits in power_and_test and only reset clears it
   wire locked = powerTest_q[`IAPC_PT_LOCK];
   wire cfgWr = dataWrite && !locked;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_q <= 8'h00;
         ioAddr_q <= `IAPC_RST_IO_ADDR;
         powerTest_q <= `IAPC_RST_POWER_TEST;
         funcCtrl_q <= `IAPC_RST_FUNC_CTRL;
         prnCtrl_q <= `IAPC_RST_PRN_CTRL;
      end else begin
         // Index write selects the data location
         if (idxWrite) begin
            index_q <= hostWrData;
         end
         if (cfgWr) begin
            case (index_q)
               `IAPC_IDX_IO_ADDR: begin
                  ioAddr_q <= hostWrData;
               end
               `IAPC_IDX_POWER_TEST: begin
                  powerTest_q <= hostWrData;
               end
               `IAPC_IDX_FUNC_CTRL: begin
                  funcCtrl_q <= hostWrData;
               end
               `IAPC_IDX_PRN_CTRL: begin
                  prnCtrl_q <= hostWrData;
               end
               default: begin
                  // Other indices belong to other banks
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Read mux
   // ************************************************************
   reg [7:0] rdMux;
   always @* begin
      case (index_q)
         `IAPC_IDX_IO_ADDR: rdMux = ioAddr_q;
         `IAPC_IDX_POWER_TEST: rdMux = powerTest_q;
         `IAPC_IDX_FUNC_CTRL: rdMux = funcCtrl_q;
         `IAPC_IDX_PRN_CTRL: rdMux = prnCtrl_q;
         default: rdMux = 8'h00;
      endcase
   end

   // ************************************************************
   // Address routing
   // ************************************************************
   reg [9:0] com3Base;
   reg [9:0] com4Base;
   // Bases for the two extra serial slots
   always @* begin
      case (ioAddr_q[7:6])
         2'h0: begin
            com3Base = 10'h3e8;
            com4Base = 10'h2e8;
         end
         2'h1: begin
            com3Base = 10'h338;
            com4Base = 10'h238;
         end
         2'h2: begin
            com3Base = 10'h2e8;
            com4Base = 10'h2e0;
         end
         default: begin
            com3Base = 10'h220;
            com4Base = 10'h228;
         end
      endcase
   end
   wire [9:0] u1Base;
   wire [9:0] u2Base;
   wire u1OnIrq4;
   wire u2OnIrq4;
   iapc_uart_sel uSel1 (
      .sel(ioAddr_q[3:2]),
      .com3Base(com3Base),
      .com4Base(com4Base),
      .base(u1Base),
      .onIrq4(u1OnIrq4)
   );
   iapc_uart_sel uSel2 (
      .sel(ioAddr_q[5:4]),
      .com3Base(com3Base),
      .com4Base(com4Base),
      .base(u2Base),
      .onIrq4(u2OnIrq4)
   );
   wire parEn = functionEnable[0];
   wire irqGateOff = !sCtr4 && !prnCtrl_q[`IAPC_PC_ECP];
   wire [9:0] pBase;
   wire pValid;
   wire useIrq5;
   wire useIrq7;
   iapc_par_route uPar (
      .addrSel(ioAddr_q[1:0]),
      .pnpOverride(plugPlayCfg0[4]),
      .pnpAlt(plugPlayCfg0[5]),
      .irq7Sel(powerTest_q[`IAPC_PT_IRQ7SEL]),
      .portEnable(parEn),
      .irqGateOff(irqGateOff),
      .base(pBase),
      .valid(pValid),
      .useIrq5(useIrq5),
      .useIrq7(useIrq7)
   );

   // ************************************************************
   // Mode decode
   // ************************************************************
   wire eppBit = prnCtrl_q[`IAPC_PC_EPP];
   wire ecpBit = prnCtrl_q[`IAPC_PC_ECP];
   reg [2:0] modeD;
   always @* begin
      if (!parEn) begin
         modeD = `IAPC_PM_NONE;
      end else if (eppBit && !ecpBit) begin
         modeD = `IAPC_PM_EPP;
      end else if (ecpBit && !eppBit) begin
         modeD = `IAPC_PM_ECP;
      end else if (!eppBit && !ecpBit) begin
         modeD = powerTest_q[`IAPC_PT_EXTMODE] ? `IAPC_PM_EXT : `IAPC_PM_COMPAT;
      end else begin
         // Both enables set: undefined, treat as ECP
         modeD = `IAPC_PM_ECP;
      end
   end
   wire eppEcp = (modeD == `IAPC_PM_EPP) || (modeD == `IAPC_PM_ECP);

   // ************************************************************
   // Serial interrupt floating
   // ************************************************************
   // Each UART counts as unused on a line when unrouted, off or masked
   wire u1Off = !functionEnable[1] || !sMcr13 || sMcr14;
   wire u2Off = !functionEnable[2] || !sMcr23 || sMcr24;
   reg irq3Drive;
   reg irq4Drive;
   always @* begin
      if (plugPlayCfg1[0]) begin
         irq3Drive = !((plugPlayCfg1[2] || u1Off) && (plugPlayCfg1[6] || u2Off));
         irq4Drive = !((!plugPlayCfg1[2] || u1Off) && (!plugPlayCfg1[6] || u2Off));
      end else begin
         irq3Drive = (!u1OnIrq4 && !u1Off) || (!u2OnIrq4 && !u2Off);
         irq4Drive = (u1OnIrq4 && !u1Off) || (u2OnIrq4 && !u2Off);
      end
   end
   wire u1On3 = plugPlayCfg1[0] ? !plugPlayCfg1[2] : !u1OnIrq4;
   wire u2On3 = plugPlayCfg1[0] ? !plugPlayCfg1[6] : !u2OnIrq4;
   wire irq3Level = (u1On3 && !u1Off && sU1Irq) || (u2On3 && !u2Off && sU2Irq);
   wire irq4Level = (!u1On3 && !u1Off && sU1Irq) || (!u2On3 && !u2Off && sU2Irq);

   // ************************************************************
   // Parallel interrupt drive
   // ************************************************************
   // ECP term never masks, as ECP mode needs the ECP bit; polarity bit inverts default
   wire parIrqAct = sParIrq && !(modeD == `IAPC_PM_ECP && !ecpBit);
   wire parLevel = parIrqAct ^ prnCtrl_q[`IAPC_PC_POL];
   // Open drain drives only the low level
   wire odMode = prnCtrl_q[`IAPC_PC_OD];
   wire parOe5 = useIrq5 && (!odMode || !parLevel);
   wire parOe7 = useIrq7 && (!odMode || !parLevel);

   // ************************************************************
   // Output registers
   // ************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hostRdData <= 8'h00;
         parBase <= 10'h000;
         parDecodeEn <= 1'b0;
         uart1Base <= 10'h000;
         uart2Base <= 10'h000;
         parMode <= `IAPC_PM_NONE;
         parLevelIrq <= 1'b0;
         eppRegsEn <= 1'b0;
         ecpRegsEn <= 1'b0;
         ecpClkRun <= 1'b0;
         ctrlPushPull <= 1'b0;
         softPowerDown <= 1'b0;
         tapeCompat <= 1'b0;
         ideDmaEn <= 1'b0;
         rtcRamWriteEn <= 1'b1;
         serialOut1 <= 1'b1;
         serialOut2 <= 1'b1;
         irq3Out <= 1'b0;
         irq3Oe <= 1'b0;
         irq4Out <= 1'b0;
         irq4Oe <= 1'b0;
         irq5Out <= 1'b0;
         irq5Oe <= 1'b0;
         irq7Out <= 1'b0;
         irq7Oe <= 1'b0;
         zeroWaitOut <= 1'b0;
         zeroWaitOe <= 1'b0;
      end else begin
         // Data location returns the indexed register
         if (dataRead) begin
            hostRdData <= rdMux;
         end
         parBase <= pBase;
         parDecodeEn <= parEn && pValid;
         uart1Base <= u1Base;
         uart2Base <= u2Base;
         parMode <= modeD;
         // Level interrupt only in extended mode; EPP/ECP always pulse
         parLevelIrq <= (modeD == `IAPC_PM_EXT);
         eppRegsEn <= parEn && eppBit && !ecpBit;
         // Software setting ECP with a bad control value is its own hazard
         ecpRegsEn <= parEn && ecpBit;
         ecpClkRun <= ecpBit && (!sPdMode[1] || prnCtrl_q[`IAPC_PC_ECPCLK]);
         ctrlPushPull <= prnCtrl_q[`IAPC_PC_EPPVER];
         softPowerDown <= powerTest_q[`IAPC_PT_PWRDN];
         tapeCompat <= !enhancedTapeSelect && funcCtrl_q[`IAPC_FC_TAPE];
         ideDmaEn <= funcCtrl_q[`IAPC_FC_IDEDMA];
         rtcRamWriteEn <= !prnCtrl_q[`IAPC_PC_RTCMASK];
         // Test mode replaces data with the baud clock while the LCR bit 7 input is set
         serialOut1 <= (powerTest_q[`IAPC_PT_TEST1] && sLcr1) ? sBaud1 : serial_out_1;
         serialOut2 <= (powerTest_q[`IAPC_PT_TEST2] && sLcr2) ? sBaud2 : serial_out_2;
         irq3Out <= irq3Level;
         irq3Oe <= irq3Drive;
         irq4Out <= irq4Level;
         irq4Oe <= irq4Drive;
         irq5Out <= parLevel;
         irq5Oe <= parOe5;
         irq7Out <= parLevel;
         irq7Oe <= parOe7;
         // Open drain: only ever drives low
         zeroWaitOut <= 1'b0;
         zeroWaitOe <= funcCtrl_q[`IAPC_FC_ZWS] && eppEcp && sFast;
      end
   end
   // Unused synchronised control bits kept for later decode
   wire unusedCtr = |sCtrLow;
endmodule

/* inc/iapc_map.vh */
// Offsets, field positions, reset values and decode constants for the config bank.
// Assumes inclusion by bare name from the rtl files.
`ifndef IAPC_MAP_VH
`define IAPC_MAP_VH
// ************************************************************
// Register indices
// ************************************************************
`define IAPC_IDX_FUNC_ENABLE 8'h00
`define IAPC_IDX_IO_ADDR 8'h01
`define IAPC_IDX_POWER_TEST 8'h02
`define IAPC_IDX_FUNC_CTRL 8'h03
`define IAPC_IDX_PRN_CTRL 8'h04
// ************************************************************
// Reset values
// ************************************************************
`define IAPC_RST_IO_ADDR 8'h01
`define IAPC_RST_POWER_TEST 8'h00
`define IAPC_RST_FUNC_CTRL 8'h01
`define IAPC_RST_PRN_CTRL 8'h00
// ************************************************************
// Field positions
// ************************************************************
`define IAPC_PT_PWRDN 0
`define IAPC_PT_IRQ7SEL 3
`define IAPC_PT_TEST1 4
`define IAPC_PT_TEST2 5
`define IAPC_PT_LOCK 6
`define IAPC_PT_EXTMODE 7
`define IAPC_FC_TAPE 0
`define IAPC_FC_IDEDMA 1
`define IAPC_FC_ZWS 5
`define IAPC_PC_EPP 0
`define IAPC_PC_EPPVER 1
`define IAPC_PC_ECP 2
`define IAPC_PC_ECPCLK 3
`define IAPC_PC_POL 5
`define IAPC_PC_OD 6
`define IAPC_PC_RTCMASK 7
// ************************************************************
// Parallel port modes and address bases
// ************************************************************
`define IAPC_PM_NONE 3'h0
`define IAPC_PM_COMPAT 3'h1
`define IAPC_PM_EXT 3'h2
`define IAPC_PM_EPP 3'h3
`define IAPC_PM_ECP 3'h4
`define IAPC_PAR_B 10'h378
`define IAPC_PAR_A 10'h3bc
`define IAPC_PAR_C 10'h278
`define IAPC_SERIAL_PORT_1 10'h3f8
`define IAPC_SERIAL_PORT_2 10'h2f8
`endif

/* rtl/iapc_uart_sel.v */
// Resolves one UART's base address from its two-bit selector.
// Assumes the serial_port_3/4 bases are supplied by the caller.
`timescale 1ns/1ps
`include "iapc_map.vh"
module iapc_uart_sel (
   input wire [1:0] sel,
   input wire [9:0] com3Base,
   input wire [9:0] com4Base,
   output reg [9:0] base,
   output reg onIrq4
);
   // ************************************************************
   // Four-way decode
   // ************************************************************
   always @* begin
      case (sel)
         2'h0: begin
            base = `IAPC_SERIAL_PORT_1;
            onIrq4 = 1'b1;
         end
         2'h1: begin
            base = `IAPC_SERIAL_PORT_2;
            onIrq4 = 1'b0;
         end
         2'h2: begin
            base = com3Base;
            onIrq4 = 1'b1;
         end
         default: begin
            base = com4Base;
            onIrq4 = 1'b0;
         end
      endcase
   end
endmodule

/* rtl/iapc_par_route.v */
// Parallel port address and interrupt routing, purely combinational.
// Assumes all inputs are stable register or synchronised values.
`timescale 1ns/1ps
`include "iapc_map.vh"
module iapc_par_route (
   input wire [1:0] addrSel,
   input wire pnpOverride,
   input wire pnpAlt,
   input wire irq7Sel,
   input wire portEnable,
   input wire irqGateOff,
   output reg [9:0] base,
   output reg valid,
   output reg useIrq5,
   output reg useIrq7
);
   // ************************************************************
   // Routing
   // ************************************************************
   always @* begin
      base = `IAPC_PAR_B;
      valid = 1'b1;
      useIrq5 = 1'b0;
      useIrq7 = 1'b0;
      if (pnpOverride) begin
         // Selector bits ignored under the override
         base = pnpAlt ? `IAPC_PAR_C : `IAPC_PAR_B;
         useIrq5 = !pnpAlt && portEnable;
         useIrq7 = pnpAlt && portEnable;
      end else begin
         case (addrSel)
            2'h0: begin
               base = `IAPC_PAR_B;
               useIrq5 = !irq7Sel;
               useIrq7 = irq7Sel;
            end
            2'h1: begin
               base = `IAPC_PAR_A;
               useIrq7 = 1'b1;
            end
            2'h2: begin
               base = `IAPC_PAR_C;
               useIrq5 = 1'b1;
            end
            default: begin
               // Reserved code, interrupt floated
               valid = 1'b0;
            end
         endcase
      end
      if (irqGateOff) begin
         useIrq5 = 1'b0;
         useIrq7 = 1'b0;
      end
   end
endmodule

/* verification/iapc_cfg_bank_asserts.sv */
// Port checker for the configuration bank: lock, readback and decode timing.
// Assumes one-cycle host strobes and outputs one register behind their cause.
`timescale 1ns/1ps
module iapc_cfg_asserts (
   input wire core_clk,
   input wire rst_n,
   input wire idxWrite,
   input wire dataWrite,
   input wire dataRead,
   input wire [7:0] hostWrData,
   input wire [7:0] hostRdData,
   input wire [7:0] functionEnable,
   input wire [7:0] plugPlayCfg0,
   input wire [9:0] parBase,
   input wire parDecodeEn,
   input wire [2:0] parMode,
   input wire softPowerDown,
   input wire ideDmaEn,
   input wire rtcRamWriteEn,
   input wire irq5Oe,
   input wire irq7Oe,
   input wire zeroWaitOut,
   input wire zeroWaitOe
);
   // ************
   // Shadow state
   // ************
   reg [7:0] idx_q; // Index as the host set it
   reg lock_q; // Write lock seen on the bus
   reg [1:0] up_q; // Cycles since reset, saturating
   wire up = (up_q == 2'h3);
   wire wrCfg = up && dataWrite && !lock_q;
   // Mirror index and lock; old index wins in a shared cycle
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= 8'h00;
         lock_q <= 1'b0;
         up_q <= 2'h0;
      end else begin
         if (idxWrite) begin
            idx_q <= hostWrData;
         end
         if (dataWrite && idx_q == 8'h02 && hostWrData[6]) begin
            lock_q <= 1'b1;
         end
         if (!up) begin
            up_q <= up_q + 2'h1;
         end
      end
   end
   // ************
   // Properties
   // ************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_lock_holds: assert property (lock_q && dataWrite |-> ##2 ideDmaEn == $past(ideDmaEn, 2))
      else $error("locked write changed a decoded output");
   a_dma_follows: assert property (wrCfg && idx_q == 8'h03 |-> ##2 ideDmaEn == $past(hostWrData[1], 2))
      else $error("dma enable does not follow its bit");
   a_rtc_mask: assert property (wrCfg && idx_q == 8'h04 |-> ##2 rtcRamWriteEn == !$past(hostWrData[7], 2))
      else $error("rtc write enable wrong");
   a_soft_pdown: assert property (wrCfg && idx_q == 8'h02 |-> ##2 softPowerDown == $past(hostWrData[0], 2))
      else $error("soft power-down wrong");
   a_unmapped_read: assert property (up && dataRead && (idx_q == 8'h00 || idx_q > 8'h04) |-> ##[1:2] hostRdData == 8'h00)
      else $error("unmapped index read nonzero");
   a_none_mode: assert property (!functionEnable[0] [*2] |-> parMode == 3'h0 && !parDecodeEn)
      else $error("port active while disabled");
   a_override_base: assert property (up && plugPlayCfg0[4] && $stable(plugPlayCfg0[5:4]) && functionEnable[0] && $stable(functionEnable[0]) |-> parBase == (plugPlayCfg0[5] ? 10'h278 : 10'h378))
      else $error("override base wrong");
   a_override_float: assert property (up && plugPlayCfg0[4] && $stable(plugPlayCfg0[4]) && !functionEnable[0] && $stable(functionEnable[0]) |-> !irq5Oe && !irq7Oe)
      else $error("parallel irq driven while disabled");
   a_zero_wait: assert property (zeroWaitOe |-> !zeroWaitOut && (parMode == 3'h3 || parMode == 3'h4))
      else $error("zero wait driven high");
   c_lock: cover property (lock_q && dataWrite);
   c_unmapped: cover property (dataRead && idx_q > 8'h04);
   c_override7: cover property (plugPlayCfg0[4] && irq7Oe);
endmodule

bind iapc_cfg_bank iapc_cfg_asserts i_chk (.core_clk, .rst_n, .idxWrite, .dataWrite, .dataRead,
   .hostWrData, .hostRdData, .functionEnable, .plugPlayCfg0, .parBase, .parDecodeEn, .parMode,
   .softPowerDown, .ideDmaEn, .rtcRamWriteEn, .irq5Oe, .irq7Oe, .zeroWaitOut, .zeroWaitOe);

/* verification/tb.sv */
// Self-checking bench for the configuration bank through its index/data port.
// Assumes the checker file is compiled beside it; inputs change on falling edges.
`timescale 1ns/1ps
module tb;
   // ************
   // Signals
   // ************
   logic core_clk, rst_n, idxWrite, dataWrite, dataRead, enhancedTapeSelect, portCtrlBit4;
   logic [7:0] hostWrData, functionEnable, plugPlayCfg0, plugPlayCfg1;
   logic modemCtrl1Bit3, modemCtrl1Bit4, modemCtrl2Bit3, modemCtrl2Bit4, lineCtrl1Bit7;
   logic lineCtrl2Bit7, baudClk1, baudClk2, uartOut1, uartOut2, fastCycleReady, parIrqRaw;
   logic uart1Irq, uart2Irq;
   logic [2:0] portCtrlLow;
   logic [1:0] powerDownMode;
   wire [7:0] hostRdData;
   wire [9:0] parBase, uart1Base, uart2Base;
   wire [2:0] parMode;
   wire parDecodeEn, parLevelIrq, eppRegsEn, ecpRegsEn, ecpClkRun, ctrlPushPull, softPowerDown;
   wire tapeCompat, ideDmaEn, rtcRamWriteEn, serialOut1, serialOut2, irq3Out, irq3Oe, irq4Out;
   wire irq4Oe, irq5Out, irq5Oe, irq7Out, irq7Oe, zeroWaitOut, zeroWaitOe;
   int nMismatch = 0;
   int checksDone = 0;
   iapc_cfg_bank i_dut (.core_clk, .rst_n, .idxWrite, .dataWrite, .dataRead, .hostWrData,
      .hostRdData, .functionEnable, .plugPlayCfg0, .plugPlayCfg1, .enhancedTapeSelect,
      .portCtrlBit4, .portCtrlLow, .modemCtrl1Bit3, .modemCtrl1Bit4, .modemCtrl2Bit3,
      .modemCtrl2Bit4, .lineCtrl1Bit7, .lineCtrl2Bit7, .baudClk1, .baudClk2, .uartOut1,
      .uartOut2, .fastCycleReady, .parIrqRaw, .uart1Irq, .uart2Irq, .powerDownMode, .parBase,
      .parDecodeEn, .uart1Base, .uart2Base, .parMode, .parLevelIrq, .eppRegsEn, .ecpRegsEn,
      .ecpClkRun, .ctrlPushPull, .softPowerDown, .tapeCompat, .ideDmaEn, .rtcRamWriteEn,
      .serialOut1, .serialOut2, .irq3Out, .irq3Oe, .irq4Out, .irq4Oe, .irq5Out, .irq5Oe,
      .irq7Out, .irq7Oe, .zeroWaitOut, .zeroWaitOe);
   // 200 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ************
   // Helpers
   // ************
   task automatic final_report;
      if (nMismatch == 0 && checksDone > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [9:0] s, input logic [9:0] e);
      checksDone++;
      if (s !== e) begin
         nMismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Index cycle then data cycle; waits out decode and sync latency
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      hostWrData = i;
      idxWrite = 1'b1;
      cyc(1);
      idxWrite = 1'b0;
      hostWrData = d;
      dataWrite = 1'b1;
      cyc(1);
      dataWrite = 1'b0;
      cyc(4);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      hostWrData = i;
      idxWrite = 1'b1;
      cyc(1);
      idxWrite = 1'b0;
      dataRead = 1'b1;
      cyc(1);
      dataRead = 1'b0;
      cyc(2);
      chk(hostRdData, e);
   endtask
   // Expected UART base for a two-bit code and the port three/four selector
   function automatic logic [9:0] ub(input logic [1:0] c, input logic [1:0] h);
      logic [9:0] t [4] = '{10'h3f8, 10'h2f8, 10'h000, 10'h000};
      logic [9:0] c3 [4] = '{10'h3e8, 10'h338, 10'h2e8, 10'h220};
      logic [9:0] c4 [4] = '{10'h2e8, 10'h238, 10'h2e0, 10'h228};
      t[2] = c3[h];
      t[3] = c4[h];
      return t[c];
   endfunction
   // ************
   // Scenarios
   // ************
   task automatic t_reset;
      rd(8'h01, 8'h01);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h01);
      rd(8'h04, 8'h00);
      rd(8'h07, 8'h00);
      chk(rtcRamWriteEn, 1);
      chk(tapeCompat, 1);
   endtask
   task automatic t_par;
      logic [9:0] pb [4] = '{10'h378, 10'h3bc, 10'h278, 10'h000};
      for (int i = 0; i < 8; i++) begin
         wr(8'h02, {4'h0, i[2], 3'h0});
         wr(8'h01, {6'h00, i[1:0]});
         if (i[1:0] != 2'h3) chk(parBase, pb[i[1:0]]);
         chk(parDecodeEn, i[1:0] != 2'h3);
         chk(irq5Oe, (i[1:0] == 0 && !i[2]) || i[1:0] == 2);
         chk(irq7Oe, (i[1:0] == 0 && i[2]) || i[1:0] == 1);
      end
      plugPlayCfg0 = 8'h10;
      cyc(3);
      chk(parBase, 10'h378);
      chk(irq7Oe, 0);
      plugPlayCfg0 = 8'h30;
      cyc(3);
      chk(parBase, 10'h278);
      chk(irq7Oe, 1);
      functionEnable = 8'h00;
      cyc(3);
      chk(irq7Oe, 0);
      chk(parMode, 3'h0);
      functionEnable = 8'h01;
      plugPlayCfg0 = 8'h00;
      // Polarity and open-drain on the routed line
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h00);
      parIrqRaw = 1'b1;
      cyc(4);
      chk(irq5Out, 1);
      wr(8'h04, 8'h20);
      chk(irq5Out, 0);
      wr(8'h04, 8'h40);
      chk(irq5Oe, 0);
      parIrqRaw = 1'b0;
      cyc(4);
      chk(irq5Oe, 1);
      wr(8'h04, 8'h00);
      portCtrlBit4 = 1'b0;
      cyc(4);
      chk(irq5Oe, 0);
      portCtrlBit4 = 1'b1;
   endtask
   task automatic t_uart;
      for (int i = 0; i < 16; i++) begin
         wr(8'h01, {i[3:2], ~i[1:0], i[1:0], 2'h0});
         chk(uart1Base, ub(i[1:0], i[3:2]));
         chk(uart2Base, ub(~i[1:0], i[3:2]));
      end
   endtask
   task automatic t_modes;
      logic [7:0] pt [4] = '{8'h00, 8'h80, 8'h80, 8'h80};
      logic [7:0] pc [4] = '{8'h00, 8'h00, 8'h01, 8'h04};
      for (int i = 0; i < 4; i++) begin
         wr(8'h02, pt[i]);
         wr(8'h04, pc[i]);
         chk(parMode, i + 1);
         chk(parLevelIrq, i == 1);
         chk(eppRegsEn, i == 2);
         chk(ecpRegsEn, i == 3);
      end
      powerDownMode = 2'h2;
      cyc(4);
      chk(ecpClkRun, 0);
      wr(8'h04, 8'h0c);
      chk(ecpClkRun, 1);
      powerDownMode = 2'h0;
      wr(8'h04, 8'h03);
      chk(ctrlPushPull, 1);
      wr(8'h03, 8'h20);
      fastCycleReady = 1'b1;
      cyc(4);
      chk(zeroWaitOe, 1);
      chk(zeroWaitOut, 0);
      fastCycleReady = 1'b0;
      cyc(4);
      chk(zeroWaitOe, 0);
      wr(8'h04, 8'h81);
      chk(rtcRamWriteEn, 0);
   endtask
   task automatic t_misc;
      wr(8'h03, 8'h02);
      chk(ideDmaEn, 1);
      chk(tapeCompat, 0);
      wr(8'h02, 8'h01);
      chk(softPowerDown, 1);
      {lineCtrl1Bit7, lineCtrl2Bit7, uartOut1, uartOut2} = 4'hf;
      wr(8'h02, 8'h30);
      chk(serialOut1, 0);
      chk(serialOut2, 0);
      {baudClk1, baudClk2} = 2'h3;
      cyc(4);
      chk(serialOut1, 1);
      {baudClk1, baudClk2} = 2'h0;
      wr(8'h02, 8'h00);
      chk(serialOut2, 1);
      // Serial lines: first UART routed to the IRQ4 line
      plugPlayCfg1 = 8'h05;
      functionEnable = 8'h07;
      {modemCtrl1Bit3, uart1Irq} = 2'h3;
      cyc(4);
      chk(irq4Oe, 1);
      chk(irq4Out, 1);
      chk(irq3Oe, 0);
      modemCtrl1Bit4 = 1'b1;
      cyc(4);
      chk(irq4Oe, 0);
      // Address selection routing: first UART sits at port four, on IRQ3
      {plugPlayCfg1, modemCtrl1Bit4} = 9'h000;
      cyc(4);
      chk(irq3Oe, 1);
      chk(irq3Out, 1);
   endtask
   task automatic t_lock;
      wr(8'h02, 8'h40);
      wr(8'h03, 8'h00);
      chk(ideDmaEn, 1);
      rd(8'h02, 8'h40);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(2);
      rd(8'h02, 8'h00);
      wr(8'h03, 8'h02);
      chk(ideDmaEn, 1);
   endtask
   // ************
   // Main sequence and watchdog
   // ************
   initial begin
      {idxWrite, dataWrite, dataRead, hostWrData, enhancedTapeSelect} = '0;
      {modemCtrl1Bit3, modemCtrl1Bit4, modemCtrl2Bit3, modemCtrl2Bit4} = '0;
      {lineCtrl1Bit7, lineCtrl2Bit7, baudClk1, baudClk2, uartOut1, uartOut2} = '0;
      {fastCycleReady, parIrqRaw, uart1Irq, uart2Irq, powerDownMode} = '0;
      {plugPlayCfg0, plugPlayCfg1} = '0;
      functionEnable = 8'h01;
      portCtrlBit4 = 1'b1;
      portCtrlLow = 3'h1;
      rst_n = 1'b0;
      cyc(12);
      rst_n = 1'b1;
      cyc(1);
      t_reset();
      t_par();
      t_uart();
      t_modes();
      t_misc();
      t_lock();
      final_report();
   end
   // Whole run is well under 1500 cycles
   initial begin
      #20000;
      nMismatch++;
      final_report();
   end
endmodule
